/* File: rtl/pewc_pkg.sv */
// constants and types shared by the parallel nonvolatile memory write controller
package pewc_pkg;

    // bus geometry
    localparam int ADDR_W      = 13;
    localparam int DATA_W      = 8;
    localparam int PAGE_BITS   = 6;
    localparam int PAGE_W      = ADDR_W - PAGE_BITS;
    localparam int SEQ_LEN     = 3;

    // identification area sits on the top page of the map
    localparam logic [PAGE_W-1:0] ID_PAGE = 7'h7F;

    // data bus bit positions used for completion detection
    localparam int POLL_BIT    = 7;
    localparam int TOGGLE_BIT  = 6;

    // clock and printed times
    localparam int CLK_PERIOD_NS       = 100;
    localparam int READ_ACCESS_NS      = 70;
    localparam int WRITE_PULSE_NS      = 100;
    localparam int BYTE_LOAD_WINDOW_NS = 150000;
    localparam int PROGRAM_CYCLE_NS    = 2000000;
    localparam int POWER_ON_DELAY_NS   = 5000000;

    // cycle counts: least times round up, longest round down
    localparam int READ_CYC  = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WP_CYC    = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLC_CYC   = BYTE_LOAD_WINDOW_NS / CLK_PERIOD_NS;
    localparam int PROG_CYC_DEF  = (PROGRAM_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWER_CYC_DEF = (POWER_ON_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // input synchroniser depth and the pin register stage
    localparam int SYNC_STAGES = 2;
    localparam int PIN_STAGES  = 1;
    localparam int RD_WAIT_CYC = READ_CYC + SYNC_STAGES + PIN_STAGES;
    // cycles from taking a page byte to the strobe falling at the pin
    localparam int WR_LEAD_CYC = 3;
    localparam int BLC_GUARD   = BLC_CYC - WR_LEAD_CYC;

    // sequence index meaning "user data byte, no command byte left"
    localparam logic [1:0] SEQ_DATA = 2'h3;

    // user operations
    typedef enum logic [1:0] {
        OP_READ     = 2'h0,
        OP_WRITE    = 2'h1,
        OP_LOCK_ON  = 2'h2,
        OP_LOCK_OFF = 2'h3
    } pewc_op_t;

    // controller states, one-hot
    typedef enum logic [6:0] {
        ST_IDLE   = 7'h01,
        ST_RD     = 7'h02,
        ST_WR_SET = 7'h04,
        ST_WR_LOW = 7'h08,
        ST_WR_REL = 7'h10,
        ST_LOAD   = 7'h20,
        ST_POLL   = 7'h40
    } pewc_state_t;

endpackage

/* File: rtl/pewc_host.sv */
// host-side controller driving a byte-wide nonvolatile memory through its pins
// Operation
// RULE1 - read: chip select and output enable low, write strobe high, then sample data.
// RULE2 - data bus released by memory whenever chip select or output enable high.
// RULE3 - write starts with write strobe pulse low while chip select low, output enable high.
// RULE4 - address captured at later falling edge; address held through the whole pulse.
// RULE5 - data captured at earlier rising edge; data driven until after strobe rises.
// RULE6 - memory self-times programming; host only waits and polls.
// RULE7 - during programming reads return status, so host treats them as polls.
// RULE8 - one to sixty-four bytes loaded per load period, programmed together.
// RULE9 - next page byte within 150 us, otherwise load period closes.
// RULE10 - upper address bits identical for every byte of one load period.
// RULE11 - six lowest address bits select position in the page buffer.
// RULE12 - page bytes in any order; reloads overwrite; only loaded bytes programmed.
// RULE13 - during programming bit 7 of last written byte reads inverted.
// RULE14 - during programming bit 6 changes on every read, stops when done.
// RULE15 - no write starts while output enable low, chip select high or strobe high.
// RULE16 - strobe pulses shorter than about 15 ns never start a write.
// RULE17 - writes blocked for about 5 ms after power comes up.
// RULE18 - lock enabled by a three-byte command sequence, effective after one program period.
// RULE19 - locked memory still writes data preceded by the same three-byte sequence.
// RULE20 - lock survives power cycles, cleared only by the disable sequence.
// RULE21 - command bytes are not stored; command addresses stay usable for data.
// RULE22 - locked unprefixed write starts the timer but changes nothing; reads poll.
// RULE23 - high voltage on address bit 9 maps top 64 addresses to the id area.
// RULE24 - the three address and data pairs of each sequence are parameters.
// RULE25 - command sequences use page load timing, forming one load period with data.
`timescale 1ns/10ps
module pewc_host
    import pewc_pkg::*;
#(
    parameter int PROG_CYC  = PROG_CYC_DEF,
    parameter int POWER_CYC = POWER_CYC_DEF,
    parameter logic [ADDR_W-1:0] LOCK_ON_ADDR  [SEQ_LEN] = '{13'h0123, 13'h0456, 13'h0789},
    parameter logic [DATA_W-1:0] LOCK_ON_DATA  [SEQ_LEN] = '{8'h11, 8'h22, 8'h33},
    parameter logic [ADDR_W-1:0] LOCK_OFF_ADDR [SEQ_LEN] = '{13'h0123, 13'h0456, 13'h0789},
    parameter logic [DATA_W-1:0] LOCK_OFF_DATA [SEQ_LEN] = '{8'h11, 8'h22, 8'h44}
) (
    // clock and reset
    input  wire logic              CLK_I,
    input  wire logic              RESETN_I,
    // user request port
    input  wire logic              REQ_VALID_I,
    output logic                   REQ_READY_O,
    input  wire pewc_op_t          REQ_OP_I,
    input  wire logic [ADDR_W-1:0] REQ_ADDR_I,
    input  wire logic [DATA_W-1:0] REQ_DATA_I,
    input  wire logic              REQ_LAST_I,
    input  wire logic              REQ_PREFIX_I,
    input  wire logic              REQ_ID_I,
    // user answer port
    output logic                   RSP_VALID_O,
    output logic [DATA_W-1:0]      RSP_DATA_O,
    output logic                   WR_DONE_O,
    output logic                   BUSY_O,
    // memory pins
    output logic [ADDR_W-1:0]      MEM_ADDR_O,
    output logic                   MEM_CE_N_O,
    output logic                   MEM_OE_N_O,
    output logic                   MEM_WE_N_O,
    output logic                   MEM_ID_HV_O,
    input  wire logic [DATA_W-1:0] MEM_DATA_I,
    output logic [DATA_W-1:0]      MEM_DATA_O,
    output logic                   MEM_DATA_OE_O
);

    ////////////////////////////////////////////////////////////////////////////////
    // declarations

    pewc_state_t       state_ff, nxt_state;
    logic [31:0]       cnt_ff, nxt_cnt;
    logic [31:0]       prog_cnt_ff;
    logic [31:0]       pwr_cnt_ff;
    logic              power_ok_ff;
    logic              poll_ff, nxt_poll;
    logic              accept;
    logic              more_seq;
    logic              rd_end;
    logic              poll_done;
    logic [DATA_W-1:0] data_s1_ff, data_s2_ff;
    logic [ADDR_W-1:0] addr_ff, last_addr_ff, cur_addr;
    logic [DATA_W-1:0] wdata_ff, cur_data;
    logic              last_ff, id_ff, cmd_only_ff, lockoff_ff, last_hv_ff, cur_hv;
    logic [1:0]        seq_idx_ff;
    logic              prev_valid_ff, prev_tog_ff;
    logic              same_page;

    ////////////////////////////////////////////////////////////////////////////////
    // pin input synchroniser; only the second stage is read

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            data_s1_ff <= 8'h00;
            data_s2_ff <= 8'h00;
        end else begin
            data_s1_ff <= MEM_DATA_I;
            data_s2_ff <= data_s1_ff;
        end
    end

    // power-up hold-off; reads may run meanwhile, writes wait
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            pwr_cnt_ff  <= 32'h0;
            power_ok_ff <= 1'b0;
        end else if (!power_ok_ff) begin
            pwr_cnt_ff  <= pwr_cnt_ff + 32'h1;
            power_ok_ff <= (pwr_cnt_ff >= 32'(POWER_CYC - 1));           // [RULE17]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sequencing

    // bytes of one load stay on one page and one area
    assign same_page = (REQ_ADDR_I[ADDR_W-1:PAGE_BITS] == addr_ff[ADDR_W-1:PAGE_BITS])
                       && (REQ_ID_I == id_ff);                            // [RULE10]
    // command bytes still to go before the data byte, or the end of a lock command
    assign more_seq  = (seq_idx_ff != SEQ_DATA) && !(cmd_only_ff && seq_idx_ff == 2'h2);
    assign rd_end    = (state_ff == ST_RD) && (cnt_ff == 32'(RD_WAIT_CYC - 1));
    // toggle bit standing still ends the wait; the timeout guards a dead part
    assign poll_done = rd_end && poll_ff && ((prev_valid_ff
                       && data_s2_ff[TOGGLE_BIT] == prev_tog_ff)          // [RULE14]
                       || prog_cnt_ff >= 32'(PROG_CYC));                  // [RULE6]

    // next state and shared wait counter
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff + 32'h1;
        nxt_poll  = poll_ff;
        accept    = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                nxt_cnt = 32'h0;
                if (REQ_VALID_I && (REQ_OP_I == OP_READ || power_ok_ff)) begin  // [RULE17]
                    accept    = 1'b1;
                    nxt_state = (REQ_OP_I == OP_READ) ? ST_RD : ST_WR_SET;
                end
            end
            ST_RD: begin
                if (rd_end) begin
                    nxt_cnt   = 32'h0;
                    nxt_state = !poll_ff ? ST_IDLE : (poll_done ? ST_IDLE : ST_POLL);
                    nxt_poll  = poll_ff && !poll_done;
                end
            end
            ST_WR_SET: begin
                nxt_cnt   = 32'h0;
                nxt_state = ST_WR_LOW;
            end
            ST_WR_LOW: begin
                if (cnt_ff == 32'(WP_CYC - 1)) begin                       // [RULE16]
                    nxt_state = ST_WR_REL;
                end
            end
            ST_WR_REL: begin
                nxt_cnt = 32'h0;
                if (more_seq) begin
                    nxt_state = ST_WR_SET;                                // [RULE25]
                end else if (last_ff || cmd_only_ff) begin
                    nxt_state = ST_POLL;
                    nxt_poll  = 1'b1;
                end else begin
                    nxt_state = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (cnt_ff >= 32'(BLC_GUARD)) begin                        // [RULE9]
                    nxt_state = ST_POLL;
                    nxt_poll  = 1'b1;
                end else if (REQ_VALID_I) begin
                    nxt_cnt = 32'h0;
                    if (REQ_OP_I == OP_WRITE && !REQ_PREFIX_I && same_page) begin  // [RULE8]
                        accept    = 1'b1;
                        nxt_state = ST_WR_SET;
                    end else begin
                        nxt_state = ST_POLL;                              // [RULE10]
                        nxt_poll  = 1'b1;
                    end
                end
            end
            ST_POLL: begin
                nxt_cnt   = 32'h0;
                nxt_state = ST_RD;                                        // [RULE7]
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_cnt   = 32'h0;
                nxt_poll  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            state_ff <= ST_IDLE;
            cnt_ff   <= 32'h0;
            poll_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            poll_ff  <= nxt_poll;
        end
    end

    assign REQ_READY_O = accept;
    assign BUSY_O      = (state_ff != ST_IDLE);

    ////////////////////////////////////////////////////////////////////////////////
    // request latch and command sequence index

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            addr_ff      <= 13'h0000;
            wdata_ff     <= 8'h00;
            last_ff      <= 1'b0;
            id_ff        <= 1'b0;
            cmd_only_ff  <= 1'b0;
            lockoff_ff   <= 1'b0;
            seq_idx_ff   <= SEQ_DATA;
            last_addr_ff <= 13'h0000;
            last_hv_ff   <= 1'b0;
        end else if (accept) begin
            addr_ff     <= REQ_ADDR_I;                                    // [RULE11]
            wdata_ff    <= REQ_DATA_I;
            last_ff     <= REQ_LAST_I;
            id_ff       <= REQ_ID_I;
            cmd_only_ff <= (REQ_OP_I == OP_LOCK_ON) || (REQ_OP_I == OP_LOCK_OFF);  // [RULE18]
            lockoff_ff  <= (REQ_OP_I == OP_LOCK_OFF);                     // [RULE20]
            // a prefixed data write reuses the enable sequence
            seq_idx_ff  <= (REQ_OP_I == OP_LOCK_ON || REQ_OP_I == OP_LOCK_OFF
                            || (REQ_OP_I == OP_WRITE && REQ_PREFIX_I)) ? 2'h0 : SEQ_DATA;  // [RULE19]
        end else if (state_ff == ST_WR_REL) begin
            // poll the location written last, command byte or data byte
            last_addr_ff <= cur_addr;                                     // [RULE13]
            last_hv_ff   <= cur_hv;
            if (more_seq) begin
                seq_idx_ff <= seq_idx_ff + 2'h1;
            end
        end
    end

    // address and data for the current access
    always_comb begin
        cur_hv   = 1'b0;
        cur_data = wdata_ff;
        if (poll_ff) begin
            cur_addr = last_addr_ff;
            cur_hv   = last_hv_ff;
        end else if (seq_idx_ff != SEQ_DATA) begin
            cur_addr = lockoff_ff ? LOCK_OFF_ADDR[seq_idx_ff] : LOCK_ON_ADDR[seq_idx_ff];  // [RULE24]
            cur_data = lockoff_ff ? LOCK_OFF_DATA[seq_idx_ff] : LOCK_ON_DATA[seq_idx_ff];
        end else if (id_ff) begin
            cur_addr = {ID_PAGE, addr_ff[PAGE_BITS-1:0]};                 // [RULE23]
            cur_hv   = 1'b1;
        end else begin
            cur_addr = addr_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin register; pins follow the state one cycle late so they never glitch

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            MEM_ADDR_O    <= 13'h0000;
            MEM_CE_N_O    <= 1'b1;
            MEM_OE_N_O    <= 1'b1;
            MEM_WE_N_O    <= 1'b1;
            MEM_ID_HV_O   <= 1'b0;
            MEM_DATA_O    <= 8'h00;
            MEM_DATA_OE_O <= 1'b0;
        end else begin
            MEM_ADDR_O    <= cur_addr;                                    // [RULE4]
            MEM_ID_HV_O   <= cur_hv && (state_ff != ST_IDLE) && (state_ff != ST_LOAD);
            MEM_CE_N_O    <= !(state_ff == ST_RD || state_ff == ST_WR_SET
                               || state_ff == ST_WR_LOW || state_ff == ST_WR_REL);  // [RULE3]
            MEM_OE_N_O    <= (state_ff != ST_RD);                         // [RULE1]
            MEM_WE_N_O    <= (state_ff != ST_WR_LOW);                     // [RULE15]
            MEM_DATA_O    <= cur_data;                                    // [RULE5]
            MEM_DATA_OE_O <= (state_ff == ST_WR_SET || state_ff == ST_WR_LOW
                              || state_ff == ST_WR_REL);                  // [RULE2]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // answers and poll bookkeeping

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            RSP_VALID_O   <= 1'b0;
            RSP_DATA_O    <= 8'h00;
            WR_DONE_O     <= 1'b0;
            prev_valid_ff <= 1'b0;
            prev_tog_ff   <= 1'b0;
            prog_cnt_ff   <= 32'h0;
        end else begin
            RSP_VALID_O <= rd_end && !poll_ff;
            WR_DONE_O   <= poll_done;
            if (rd_end && !poll_ff) begin
                RSP_DATA_O <= data_s2_ff;
            end
            // a fresh poll forgets the old toggle sample
            if (!poll_ff) begin
                prev_valid_ff <= 1'b0;
                prog_cnt_ff   <= 32'h0;
            end else begin
                prog_cnt_ff <= prog_cnt_ff + 32'h1;
                if (rd_end) begin
                    prev_valid_ff <= 1'b1;
                    prev_tog_ff   <= data_s2_ff[TOGGLE_BIT];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    AST_READ_PINS: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        !MEM_OE_N_O |-> !MEM_CE_N_O && MEM_WE_N_O && !MEM_DATA_OE_O)  // [RULE1]
        else $error("read strobes malformed");
    AST_NO_CONTENTION: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        MEM_DATA_OE_O |-> MEM_OE_N_O)  // [RULE2]
        else $error("host drives data while memory may drive");
    AST_WRITE_START: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        $fell(MEM_WE_N_O) |-> !MEM_CE_N_O && MEM_OE_N_O && MEM_DATA_OE_O)  // [RULE3]
        else $error("write pulse without select or with output enable");
    AST_ADDR_HOLD: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        $fell(MEM_WE_N_O) |=> $stable(MEM_ADDR_O) && $stable(MEM_DATA_O))  // [RULE4]
        else $error("address or data moved during write pulse");
    AST_DATA_HOLD: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        $rose(MEM_WE_N_O) |-> MEM_DATA_OE_O && !MEM_CE_N_O && $stable(MEM_DATA_O))  // [RULE5]
        else $error("data released before strobe rose");
    AST_PULSE_WIDTH: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        $fell(MEM_WE_N_O) |=> MEM_WE_N_O)  // [RULE16]
        else $error("write pulse width not one cycle");
    AST_LOAD_GAP: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        state_ff == ST_LOAD |-> cnt_ff <= 32'(BLC_GUARD))  // [RULE9]
        else $error("byte load window overrun");
    AST_SAME_PAGE: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        state_ff == ST_LOAD && accept |-> REQ_ADDR_I[ADDR_W-1:PAGE_BITS]
            == addr_ff[ADDR_W-1:PAGE_BITS])  // [RULE10]
        else $error("page changed inside one load");
    AST_POWER_HOLD: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        !power_ok_ff |-> MEM_WE_N_O)  // [RULE17]
        else $error("write issued during power-up delay");
    AST_POLL_READS: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        state_ff == ST_POLL |=> state_ff == ST_RD ##1 MEM_ADDR_O == last_addr_ff)  // [RULE13]
        else $error("poll does not read last written location");

endmodule // pewc_host

/* File: verif/pewc_mem_model.sv */
// behavioural model of the byte-wide nonvolatile memory behind the host controller
`timescale 1ns/10ps
module pewc_mem_model
    import pewc_pkg::*;
#(
    parameter int                PROG  = 50,
    parameter int                PWR   = 8,
    parameter logic [ADDR_W-1:0] ON_A  [SEQ_LEN] = '{13'h0001, 13'h0002, 13'h0003},
    parameter logic [DATA_W-1:0] ON_D  [SEQ_LEN] = '{8'h01, 8'h02, 8'h03},
    parameter logic [DATA_W-1:0] OFF_D [SEQ_LEN] = '{8'h01, 8'h02, 8'h04}
) (
    // time base for the self-timed counters and the last-read byte register
    input  wire logic              clk_i,
    // memory pins
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic              ce_n_i,
    input  wire logic              oe_n_i,
    input  wire logic              we_n_i,
    input  wire logic              hv_i,
    input  wire logic [DATA_W-1:0] dq_i,
    output logic      [DATA_W-1:0] dq_o
);
    logic [DATA_W-1:0] mem [0:8191];
    logic [DATA_W-1:0] idm [0:63];
    logic [ADDR_W:0]   pa [$];
    logic [DATA_W-1:0] pd [$];
    logic [ADDR_W:0]   a_lat;
    logic [DATA_W-1:0] last_d, last_q, rd;
    logic              lock, lock_nxt, tog;
    int                blc, prog, pwr;
    realtime           t_fall;
    // erased array, lock off as delivered
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        foreach (idm[i]) idm[i] = 8'hFF;
        lock = 1'b0;
        {lock_nxt, tog, blc, prog, pwr, last_d, last_q} = '0;
    end
    //////////////////////////////////////////////////////////////////////////////////////////
    // address taken at the strobe's falling edge, id area when the high voltage is on
    always @(negedge we_n_i) begin
        t_fall = $realtime;
        a_lat = {hv_i && addr_i[12:6] == ID_PAGE, addr_i};
    end
    // data taken at the rising edge; refused while busy, powering up, inhibited or glitching
    always @(posedge we_n_i) begin
        if (!ce_n_i && oe_n_i && prog == 0 && pwr >= PWR
            && $realtime - t_fall >= 15.0) begin
            pa.push_back(a_lat);
            pd.push_back(dq_i);
            blc = 1;
        end
    end
    // command prefix bytes are dropped; locked data without prefix only runs the timer
    task automatic close_load();
        logic on, off;
        on = pa.size() >= SEQ_LEN;
        off = on;
        for (int i = 0; i < SEQ_LEN && i < pa.size(); i++) begin
            on = on && pa[i] == {1'b0, ON_A[i]} && pd[i] == ON_D[i];
            off = off && pa[i] == {1'b0, ON_A[i]} && pd[i] == OFF_D[i];
        end
        if (!lock || on || off)
            for (int i = (on || off) ? SEQ_LEN : 0; i < pa.size(); i++)
                if (pa[i][ADDR_W]) idm[pa[i][5:0]] = pd[i];
                else mem[pa[i][ADDR_W-1:0]] = pd[i];
        lock_nxt = on ? 1'b1 : off ? 1'b0 : lock;
        last_d = pd[pd.size()-1];
        prog = PROG;
        blc = 0;
        pa.delete();
        pd.delete();
    endtask
    // load window, programming timer and power-on delay
    always @(posedge clk_i) begin
        if (pwr < PWR) pwr++;
        if (blc > 0) blc++;
        if (blc > BLC_CYC) close_load();
        else if (prog > 0) begin
            prog--;
            if (prog == 0) lock = lock_nxt;
        end
        if (!ce_n_i && !oe_n_i) last_q <= rd;
    end
    // a read ends the load first, so its data is already status; busy reads flip bit 6
    always @(negedge oe_n_i) if (!ce_n_i) begin
        if (blc > 0) close_load();
        if (prog > 0) tog = ~tog;
    end
    // released bus shows the inverse of the last byte, so stale data never passes
    always @* begin
        rd = (hv_i && addr_i[12:6] == ID_PAGE) ? idm[addr_i[5:0]] : mem[addr_i];
        if (prog > 0) rd = {~last_d[7], tog, last_d[5:0]};
        dq_o = (!ce_n_i && !oe_n_i) ? rd : ~last_q;
    end
endmodule // pewc_mem_model

/* File: verif/testbench.sv */
// self-checking testbench of the host write controller against the memory model
`timescale 1ns/10ps
`define CHK(g, e) \
    begin \
        checked++; \
        if ((g) !== (e)) begin \
            err_count++; \
            $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); \
        end \
    end
module testbench import pewc_pkg::*;;
    localparam logic [ADDR_W-1:0] ON_A  [SEQ_LEN] = '{13'h1555, 13'h0AAA, 13'h1555};
    localparam logic [DATA_W-1:0] ON_D  [SEQ_LEN] = '{8'hAA, 8'h55, 8'hA0};
    localparam logic [DATA_W-1:0] OFF_D [SEQ_LEN] = '{8'hAA, 8'h55, 8'h20};
    logic              clk, rstn, valid, last, prefix, id, ready, rsp_valid, done;
    logic              ce_n, oe_n, we_n, hv, hoe;
    pewc_op_t          op;
    logic [ADDR_W-1:0] addr, mem_addr, a;
    logic [DATA_W-1:0] data, rsp_data, mem_dq, bus, hdata, e, v;
    logic [DATA_W-1:0] exp_q [$];
    logic [6:0]        pg;
    int                err_count, checked;
    // host drives the bus while enabled, otherwise the model's value
    assign bus = hoe ? hdata : mem_dq;
    always #(CLK_PERIOD_NS / 2) clk = ~clk;
    pewc_host #(.PROG_CYC(200), .POWER_CYC(10), .LOCK_ON_ADDR(ON_A), .LOCK_ON_DATA(ON_D),
        .LOCK_OFF_ADDR(ON_A), .LOCK_OFF_DATA(OFF_D)) uut (
        .CLK_I(clk), .RESETN_I(rstn), .REQ_VALID_I(valid), .REQ_READY_O(ready),
        .REQ_OP_I(op), .REQ_ADDR_I(addr), .REQ_DATA_I(data), .REQ_LAST_I(last),
        .REQ_PREFIX_I(prefix), .REQ_ID_I(id), .RSP_VALID_O(rsp_valid), .RSP_DATA_O(rsp_data),
        .WR_DONE_O(done), .BUSY_O(), .MEM_ADDR_O(mem_addr), .MEM_CE_N_O(ce_n),
        .MEM_OE_N_O(oe_n), .MEM_WE_N_O(we_n), .MEM_ID_HV_O(hv), .MEM_DATA_I(bus),
        .MEM_DATA_O(hdata), .MEM_DATA_OE_O(hoe));
    pewc_mem_model #(.ON_A(ON_A), .ON_D(ON_D), .OFF_D(OFF_D)) mem (
        .clk_i(clk), .addr_i(mem_addr), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
        .hv_i(hv), .dq_i(bus), .dq_o(mem_dq));
    //////////////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // request held until ready is seen high before the taking edge
    task automatic req(input pewc_op_t o, input logic [12:0] ad, input logic [7:0] d,
                       input logic l, input logic p, input logic i);
        int n;
        n = 0;
        @(posedge clk);
        op <= o;
        {addr, data, last, prefix, id} <= {ad, d, l, p, i};
        valid <= 1'b1;
        do begin
            @(negedge clk);
            n++;
        end while (ready !== 1'b1 && n < 3000);
        if (n >= 3000) err_count++;
        @(posedge clk);
        valid <= 1'b0;
    endtask
    // read request; the expected byte waits in the queue for the monitor
    task automatic rd(input logic [12:0] ad, input logic i, input logic [7:0] x);
        req(OP_READ, ad, 8'h00, 1'b0, 1'b0, i);
        exp_q.push_back(x);
    endtask
    // completion is a one-cycle pulse, so look at every cycle, under a bound
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (done !== 1'b1 && n < 3000);
        if (n >= 3000) err_count++;
    endtask
    // monitor: every read answer is matched against the oldest note
    always @(negedge clk) if (rsp_valid === 1'b1) begin
        e = exp_q.pop_front();
        `CHK(rsp_data, e)
    end
    // watchdog well beyond the expected run
    initial begin
        #(10000 * CLK_PERIOD_NS);
        err_count++;
        finish_test();
    end
    initial begin
        {clk, rstn, valid, last, prefix, id, addr, data, err_count, checked} = '0;
        op = OP_READ;
        void'($urandom(32'hE3DC));
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        rd(13'h0040, 1'b0, 8'hFF);
        $display("test read_erased done");
        // page: out of order, overwrite of one position, unloaded position untouched
        pg = 7'($urandom_range(32, 1));
        v = 8'($urandom);
        req(OP_WRITE, {pg, 6'h05}, ~v, 1'b0, 1'b0, 1'b0);
        req(OP_WRITE, {pg, 6'h01}, v + 8'h01, 1'b0, 1'b0, 1'b0);
        req(OP_WRITE, {pg, 6'h05}, v, 1'b0, 1'b0, 1'b0);
        req(OP_WRITE, {pg, 6'h3F}, v + 8'h02, 1'b1, 1'b0, 1'b0);
        wait_done();
        rd({pg, 6'h05}, 1'b0, v);
        rd({pg, 6'h01}, 1'b0, v + 8'h01);
        rd({pg, 6'h3F}, 1'b0, v + 8'h02);
        rd({pg, 6'h02}, 1'b0, 8'hFF);
        $display("test page_write done");
        // single byte closed by the load window running out
        a = 13'($urandom_range(4095, 2752));
        req(OP_WRITE, a, ~v, 1'b0, 1'b0, 1'b0);
        wait_done();
        rd(a, 1'b0, ~v);
        $display("test window_close done");
        // lock: plain write dropped, prefixed write stored, command bytes never stored
        req(OP_LOCK_ON, 13'h0000, 8'h00, 1'b0, 1'b0, 1'b0);
        wait_done();
        req(OP_WRITE, a + 13'h0001, v, 1'b1, 1'b0, 1'b0);
        wait_done();
        rd(a + 13'h0001, 1'b0, 8'hFF);
        req(OP_WRITE, a + 13'h0001, v, 1'b1, 1'b1, 1'b0);
        wait_done();
        rd(a + 13'h0001, 1'b0, v);
        rd(ON_A[1], 1'b0, 8'hFF);
        $display("test lock_on done");
        // lock survives a reset in mid-run, then is cleared by the disable sequence
        repeat (8) @(posedge clk);
        rstn <= 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        req(OP_WRITE, a + 13'h0002, v, 1'b1, 1'b0, 1'b0);
        wait_done();
        rd(a + 13'h0002, 1'b0, 8'hFF);
        req(OP_LOCK_OFF, 13'h0000, 8'h00, 1'b0, 1'b0, 1'b0);
        wait_done();
        req(OP_WRITE, ON_A[1], ~v, 1'b1, 1'b0, 1'b0);
        wait_done();
        rd(ON_A[1], 1'b0, ~v);
        $display("test lock_off done");
        // identification area is separate from the top page of the array
        req(OP_WRITE, 13'h0005, v ^ 8'h5A, 1'b1, 1'b0, 1'b1);
        wait_done();
        rd(13'h0005, 1'b1, v ^ 8'h5A);
        rd(13'h1FC5, 1'b0, 8'hFF);
        repeat (10) @(posedge clk);
        `CHK(exp_q.size(), 0)
        $display("test id_area done");
        finish_test();
    end
endmodule // testbench
